// *** rcc_board.sv ***
`timescale 1ns/10ps
`default_nettype none
module rcc_board (
	input wire logic clock,
	output logic reset_in_n,
	output logic [rcc_pkg::RCC_STRAP_W-1:0] ad_strap
);
	initial begin
		reset_in_n = 1'b0;
		ad_strap = 5'h00;
	end

	// straps only meaningful around release; callers pick the code
	task automatic boot(input logic [4:0] code, input int low);
		@(negedge clock);
		reset_in_n = 1'b0;
		ad_strap = code;
		repeat (low) @(negedge clock);
		reset_in_n = 1'b1;
		// code must stand over the edge on which the synced release shows
		repeat (2) @(negedge clock);
		// hold over: pins now carry unrelated traffic, not the code
		ad_strap = ~code;
	endtask

	task automatic glitch(input int low);
		reset_in_n = 1'b0;
		repeat (low) @(negedge clock);
		reset_in_n = 1'b1;
	endtask
endmodule // rcc_board
`default_nettype wire

// *** rcc_pkg.sv ***
package rcc_pkg;

	localparam int unsigned RCC_STRAP_W = 5;
	localparam int unsigned RCC_DATA_W = 32;
	localparam int unsigned RCC_MULT_W = 3;
	localparam int unsigned RCC_CORE_W = 4;
	localparam int unsigned RCC_SYNC_STAGES = 2;

	// strap codes on the multiplexed address/data field
	localparam logic [4:0] RCC_CODE_HI_2X = 5'h03;
	localparam logic [4:0] RCC_CODE_LO_2X = 5'h05;
	localparam logic [4:0] RCC_CODE_25_4X = 5'h0f;
	localparam logic [4:0] RCC_CODE_RST = 5'h00;

	// multipliers relative to the reference input
	localparam logic [2:0] RCC_MULT_NONE = 3'h0;
	localparam logic [2:0] RCC_MULT_1X = 3'h1;
	localparam logic [2:0] RCC_MULT_2X = 3'h2;
	localparam logic [2:0] RCC_MULT_4X = 3'h4;
	localparam logic [3:0] RCC_CORE_RST = 4'h0;

	// least reset pulse, in reference cycles
	localparam logic [2:0] RCC_RST_PULSE_MIN = 3'h5;
	localparam logic [2:0] RCC_CNT_RST = 3'h0;

	// gray along hold -> capture -> run
	typedef enum logic [1:0] {
		RCC_ST_HOLD = 2'h0,
		RCC_ST_CAPT = 2'h1,
		RCC_ST_RUN = 2'h3
	} rcc_state_type;

endpackage

// *** rcc_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
module rcc_sync (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic reset_in_n,
	input wire logic [rcc_pkg::RCC_DATA_W-1:0] lb_data_in,
	rcc_sync_if.syn sif
);

	logic rst_meta_reg;
	logic rst_sync_reg;
	logic [rcc_pkg::RCC_DATA_W-1:0] data_meta_reg;
	logic [rcc_pkg::RCC_DATA_W-1:0] data_sync_reg;

	////////////////////////////////////////////////////////////////
	// first stage feeds only the second stage
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else if (ce) begin
			rst_meta_reg <= reset_in_n;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	// bits are synced one by one; a skewed word may split over a cycle
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			data_meta_reg <= '0;
			data_sync_reg <= '0;
		end else if (ce) begin
			data_meta_reg <= lb_data_in;
			data_sync_reg <= data_meta_reg;
		end
	end

	assign sif.rst_sync = rst_sync_reg;
	assign sif.data_sync = data_sync_reg;

	////////////////////////////////////////////////////////////////
	a_rst_two_stage: assert property (@(posedge clock)
		disable iff (!arst_n)
		(ce && $past(ce) && $past(arst_n, 2)) |=>
		rst_sync_reg == $past(reset_in_n, 2))
		else $error("reset sync not two stages");

	a_data_two_stage: assert property (@(posedge clock)
		disable iff (!arst_n)
		(ce && $past(ce) && $past(arst_n, 2)) |=>
		data_sync_reg == $past(lb_data_in, 2))
		else $error("data sync not two stages");

endmodule // rcc_sync
`default_nettype wire

// *** rcc_sync_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface rcc_sync_if;
	logic rst_sync;
	logic [rcc_pkg::RCC_DATA_W-1:0] data_sync;

	modport syn (output rst_sync, output data_sync);
	modport use_side (input rst_sync, input data_sync);
endinterface
`default_nettype wire

// *** rcc_top.sv ***
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Strap 00011 or 00101 selects a 1:2 ratio and 01111 selects 1:4.
// - Internal bus runs at 2x or 4x reference; memory bus equals it.
// - Local bus and PCI run at the reference rate, unmultiplied.
// - Core clock is always twice the internal bus clock.
// - Reset input and local bus data pass through synchronizers.
// - Straps are taken on the edge before release is seen, then held.
module rcc_top (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic reset_in_n,
	input wire logic [rcc_pkg::RCC_STRAP_W-1:0] ad_strap,
	input wire logic [rcc_pkg::RCC_DATA_W-1:0] lb_data_in,
	output logic core_rst_n,
	output logic [rcc_pkg::RCC_DATA_W-1:0] lb_data_sync,
	output logic [rcc_pkg::RCC_STRAP_W-1:0] ratio_code,
	output logic ratio_valid,
	output logic ratio_reserved,
	output logic [rcc_pkg::RCC_MULT_W-1:0] ref_mult,
	output logic [rcc_pkg::RCC_MULT_W-1:0] bus_mult,
	output logic [rcc_pkg::RCC_MULT_W-1:0] mem_mult,
	output logic [rcc_pkg::RCC_MULT_W-1:0] trace_mult,
	output logic [rcc_pkg::RCC_CORE_W-1:0] core_mult
);

	////////////////////////////////////////////////////////////////
	function automatic logic [rcc_pkg::RCC_MULT_W-1:0] decode_mult(
		input logic [rcc_pkg::RCC_STRAP_W-1:0] code
	);
		case (code)
			rcc_pkg::RCC_CODE_HI_2X: decode_mult = rcc_pkg::RCC_MULT_2X;
			rcc_pkg::RCC_CODE_LO_2X: decode_mult = rcc_pkg::RCC_MULT_2X;
			rcc_pkg::RCC_CODE_25_4X: decode_mult = rcc_pkg::RCC_MULT_4X;
			default: decode_mult = rcc_pkg::RCC_MULT_NONE;
		endcase
	endfunction

	function automatic logic [rcc_pkg::RCC_CORE_W-1:0] core_of(
		input logic [rcc_pkg::RCC_MULT_W-1:0] m
	);
		core_of = {m, 1'b0};
	endfunction

	////////////////////////////////////////////////////////////////
	rcc_sync_if sif ();

	rcc_sync u_sync (
		.clock(clock),
		.arst_n(arst_n),
		.ce(ce),
		.reset_in_n(reset_in_n),
		.lb_data_in(lb_data_in),
		.sif(sif.syn)
	);

	assign lb_data_sync = sif.data_sync;

	////////////////////////////////////////////////////////////////
	rcc_pkg::rcc_state_type state_reg;
	rcc_pkg::rcc_state_type state_next;
	logic sync_prev_reg;
	logic rise_seen;
	logic [2:0] low_cnt_reg;
	logic pulse_ok;
	logic [rcc_pkg::RCC_STRAP_W-1:0] strap_d_reg;
	logic [rcc_pkg::RCC_STRAP_W-1:0] code_reg;
	logic core_rst_n_reg;
	logic valid_reg;
	logic reserved_reg;
	logic [rcc_pkg::RCC_MULT_W-1:0] ref_mult_reg;
	logic [rcc_pkg::RCC_MULT_W-1:0] bus_mult_reg;
	logic [rcc_pkg::RCC_MULT_W-1:0] mem_mult_reg;
	logic [rcc_pkg::RCC_CORE_W-1:0] core_mult_reg;

	assign rise_seen = sif.rst_sync && !sync_prev_reg;
	assign pulse_ok = (low_cnt_reg >= rcc_pkg::RCC_RST_PULSE_MIN);

	////////////////////////////////////////////////////////////////
	// edge detect sits on the second stage, never the first
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			sync_prev_reg <= 1'b0;
		end else if (ce) begin
			sync_prev_reg <= sif.rst_sync;
		end
	end

	// a low no longer than the least pulse is treated as a glitch once running
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			low_cnt_reg <= rcc_pkg::RCC_CNT_RST;
		end else if (ce) begin
			if (sif.rst_sync) begin
				low_cnt_reg <= rcc_pkg::RCC_CNT_RST;
			end else if (!pulse_ok) begin
				low_cnt_reg <= low_cnt_reg + 3'h1;
			end
		end
	end

	// one-edge delay so capture uses the edge before recognition
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			strap_d_reg <= rcc_pkg::RCC_CODE_RST;
		end else if (ce) begin
			strap_d_reg <= ad_strap;
		end
	end

	////////////////////////////////////////////////////////////////
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			rcc_pkg::RCC_ST_HOLD: begin
				if (rise_seen) begin
					state_next = rcc_pkg::RCC_ST_CAPT;
				end
			end
			rcc_pkg::RCC_ST_CAPT: begin
				if (!sif.rst_sync) begin
					state_next = rcc_pkg::RCC_ST_HOLD;
				end else begin
					state_next = rcc_pkg::RCC_ST_RUN;
				end
			end
			rcc_pkg::RCC_ST_RUN: begin
				if (!sif.rst_sync && pulse_ok) begin
					state_next = rcc_pkg::RCC_ST_HOLD;
				end
			end
			default: state_next = rcc_pkg::RCC_ST_HOLD;
		endcase
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= rcc_pkg::RCC_ST_HOLD;
		end else if (ce) begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			core_rst_n_reg <= 1'b0;
		end else if (ce) begin
			core_rst_n_reg <= (state_next == rcc_pkg::RCC_ST_RUN);
		end
	end

	////////////////////////////////////////////////////////////////
	// straps held from capture until the next reset
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			code_reg <= rcc_pkg::RCC_CODE_RST;
		end else if (ce && state_reg == rcc_pkg::RCC_ST_HOLD && rise_seen) begin
			code_reg <= strap_d_reg;
		end
	end

	// reserved straps give no multiplier; the board must avoid them
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			valid_reg <= 1'b0;
			reserved_reg <= 1'b0;
			bus_mult_reg <= rcc_pkg::RCC_MULT_NONE;
			mem_mult_reg <= rcc_pkg::RCC_MULT_NONE;
			core_mult_reg <= rcc_pkg::RCC_CORE_RST;
		end else if (ce && state_reg == rcc_pkg::RCC_ST_CAPT) begin
			valid_reg <= (decode_mult(code_reg) != rcc_pkg::RCC_MULT_NONE);
			reserved_reg <= (decode_mult(code_reg) == rcc_pkg::RCC_MULT_NONE);
			bus_mult_reg <= decode_mult(code_reg);
			mem_mult_reg <= decode_mult(code_reg);
			core_mult_reg <= core_of(decode_mult(code_reg));
		end
	end

	// local bus and pci take the reference directly
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			ref_mult_reg <= rcc_pkg::RCC_MULT_1X;
		end else if (ce) begin
			ref_mult_reg <= rcc_pkg::RCC_MULT_1X;
		end
	end

	assign core_rst_n = core_rst_n_reg;
	assign ratio_code = code_reg;
	assign ratio_valid = valid_reg;
	assign ratio_reserved = reserved_reg;
	assign ref_mult = ref_mult_reg;
	assign bus_mult = bus_mult_reg;
	assign mem_mult = mem_mult_reg;
	assign trace_mult = bus_mult_reg;
	assign core_mult = core_mult_reg;

	////////////////////////////////////////////////////////////////
	a_decode_ratio: assert property (@(posedge clock)
		disable iff (!arst_n)
		(state_reg == rcc_pkg::RCC_ST_RUN) |->
		(bus_mult_reg == ((code_reg == rcc_pkg::RCC_CODE_25_4X) ?
		rcc_pkg::RCC_MULT_4X : ((code_reg == rcc_pkg::RCC_CODE_HI_2X ||
		code_reg == rcc_pkg::RCC_CODE_LO_2X) ? rcc_pkg::RCC_MULT_2X :
		rcc_pkg::RCC_MULT_NONE))))
		else $error("ratio decode wrong");

	a_mem_equals_bus: assert property (@(posedge clock)
		disable iff (!arst_n)
		mem_mult_reg == bus_mult_reg && trace_mult == bus_mult_reg)
		else $error("memory bus rate differs from bus");

	a_ref_unmultiplied: assert property (@(posedge clock)
		disable iff (!arst_n)
		ref_mult == rcc_pkg::RCC_MULT_1X)
		else $error("reference side multiplied");

	a_core_twice_bus: assert property (@(posedge clock)
		disable iff (!arst_n)
		core_mult_reg == {bus_mult_reg, 1'b0})
		else $error("core not twice bus");

	a_strap_capture: assert property (@(posedge clock)
		disable iff (!arst_n)
		(ce && rise_seen && state_reg == rcc_pkg::RCC_ST_HOLD) |=>
		(code_reg == $past(strap_d_reg)) &&
		(state_reg == rcc_pkg::RCC_ST_CAPT))
		else $error("strap not captured at release");

	a_strap_held: assert property (@(posedge clock)
		disable iff (!arst_n)
		(state_reg != rcc_pkg::RCC_ST_HOLD) |=> $stable(code_reg))
		else $error("strap changed after capture");

	a_release_order: assert property (@(posedge clock)
		disable iff (!arst_n)
		$rose(core_rst_n_reg) |->
		sif.rst_sync && $past(sif.rst_sync) && $past(state_reg) ==
		rcc_pkg::RCC_ST_CAPT)
		else $error("release before synced deassert");

	a_release_two_cyc: assert property (@(posedge clock)
		disable iff (!arst_n)
		(ce && rise_seen && state_reg == rcc_pkg::RCC_ST_HOLD) ##1
		(ce && sif.rst_sync) |=> core_rst_n_reg)
		else $error("release not two cycles after sync");

	a_glitch_ignored: assert property (@(posedge clock)
		disable iff (!arst_n)
		(state_reg == rcc_pkg::RCC_ST_RUN && !pulse_ok) |=> core_rst_n_reg)
		else $error("short reset pulse dropped core");

endmodule // rcc_top
`default_nettype wire

// *** rcc_top_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module rcc_top_tb;
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	logic ce = 1'b1;
	logic reset_in_n;
	logic [4:0] ad_strap;
	logic [31:0] lb_data_in = 32'h00000000;
	logic core_rst_n;
	logic [31:0] lb_data_sync;
	logic [4:0] ratio_code;
	logic ratio_valid;
	logic ratio_reserved;
	logic [2:0] ref_mult;
	logic [2:0] bus_mult;
	logic [2:0] mem_mult;
	logic [2:0] trace_mult;
	logic [3:0] core_mult;
	int bad_count = 0;
	int compares = 0;

	always #25 clock = ~clock;

	rcc_board u_board (.clock(clock), .reset_in_n(reset_in_n),
		.ad_strap(ad_strap));

	rcc_top u_dut (.clock(clock), .arst_n(arst_n), .ce(ce),
		.reset_in_n(reset_in_n), .ad_strap(ad_strap),
		.lb_data_in(lb_data_in), .core_rst_n(core_rst_n),
		.lb_data_sync(lb_data_sync), .ratio_code(ratio_code),
		.ratio_valid(ratio_valid), .ratio_reserved(ratio_reserved),
		.ref_mult(ref_mult), .bus_mult(bus_mult), .mem_mult(mem_mult),
		.trace_mult(trace_mult), .core_mult(core_mult));

	////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic final_report;
		if (bad_count == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	task automatic t_reset_values;
		check({31'h0, core_rst_n}, 32'h0);
		check({29'h0, ref_mult}, 32'h1);
		check({29'h0, bus_mult}, 32'h0);
		check({27'h0, ratio_code}, 32'h0);
	endtask

	// exp_bus 0 means a reserved code: flagged, no multiplier
	task automatic t_boot(input logic [4:0] code, input logic [2:0] exp_bus);
		u_board.boot(code, 10);
		check({31'h0, core_rst_n}, 32'h0);
		@(negedge clock);
		check({27'h0, ratio_code}, {27'h0, code});
		check({31'h0, core_rst_n}, 32'h0);
		@(negedge clock);
		check({31'h0, core_rst_n}, 32'h1);
		check({29'h0, bus_mult}, {29'h0, exp_bus});
		check({29'h0, mem_mult}, {29'h0, exp_bus});
		check({29'h0, trace_mult}, {29'h0, exp_bus});
		check({28'h0, core_mult}, {28'h0, exp_bus, 1'b0});
		check({29'h0, ref_mult}, 32'h1);
		check({31'h0, ratio_valid}, {31'h0, exp_bus != 3'h0});
		check({31'h0, ratio_reserved}, {31'h0, exp_bus == 3'h0});
		repeat (4) @(negedge clock);
		check({27'h0, ratio_code}, {27'h0, code});
	endtask

	// four synced low cycles must be filtered, a long low must not
	task automatic t_glitch;
		u_board.glitch(4);
		repeat (8) @(negedge clock);
		check({31'h0, core_rst_n}, 32'h1);
		u_board.glitch(12);
		check({31'h0, core_rst_n}, 32'h0);
	endtask

	task automatic t_data;
		lb_data_in = 32'ha5c3_0f96;
		@(negedge clock);
		lb_data_in = 32'h5a3c_f069;
		@(negedge clock);
		check(lb_data_sync, 32'ha5c3_0f96);
		@(negedge clock);
		check(lb_data_sync, 32'h5a3c_f069);
		ce = 1'b0;
		lb_data_in = 32'h1234_abcd;
		repeat (3) @(negedge clock);
		check(lb_data_sync, 32'h5a3c_f069);
		ce = 1'b1;
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(negedge clock);
		t_reset_values();
		arst_n = 1'b1;
		t_boot(5'h03, 3'h2);
		t_boot(5'h05, 3'h2);
		t_boot(5'h0f, 3'h4);
		t_boot(5'h1f, 3'h0);
		t_boot(5'h00, 3'h0);
		t_boot(5'h0f, 3'h4);
		t_glitch();
		t_data();
		final_report();
	end

	// whole run is near 150 cycles; this is far past it
	initial begin
		#(2000 * 50);
		bad_count++;
		final_report();
	end
endmodule // rcc_top_tb
`default_nettype wire
